// ---- rtl/rcf_pkg.sv ----
// package: register map, field positions, reset values for the reset-cause flag block
// assumes: 32-bit classic wishbone, word-aligned byte addresses
package rcf_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_WDT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam int BIT_POR = 0;
    localparam int BIT_BROWNOUT = 1;
    localparam int BIT_IDLE = 2;
    localparam int BIT_SLEEP = 3;
    localparam int FLAG_W = 4;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam int WDT_SOFT_BIT = 0;
    localparam int WDT_RUN_BIT = 1;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ---- rtl/rcf_sync.sv ----
// file: two-flop synchroniser bank for the cause inputs
// assumes: async reset already synchronised by the caller
`timescale 1ns/1ps
`default_nettype none
module rcf_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/reset_cause_flags.sv ----
// file: reset and wake cause flags with wishbone slave and interrupt
// assumes: cause inputs are levels from detectors in other domains
// Operation
// - sleep wake flag at bit 3 set when device woke from sleep
// - idle wake flag at bit 2 set when device woke from idle
// - brownout flag at bit 1 set when a brown-out reset occurred
// - power-on flag at bit 0 set when a power-on reset occurred
// - software writes all four flags to 1 or 0 together from data bits 3:0, with no per-flag mask
// - a software write only stores the flag, never starts a reset
// - fuse enable at 1 forces watchdog on, ignoring software enable
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // cause detectors, asynchronous levels
    input wire logic porEvent,
    input wire logic brownoutEvent,
    input wire logic idleWake,
    input wire logic sleepWake,
    // watchdog fuse
    input wire logic watchdogFuseEnable,
    // outputs
    output logic watchdogRun,
    output logic irq
);
    logic rstMeta_q;
    logic rstN;
    logic [3:0] causeSync;
    logic [3:0] causePrev_q;
    logic [3:0] causeRise;
    logic fuseMeta_q;
    logic fuse_q;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic watchdogSoftEnable_q;
    logic [3:0] irqStat_q;
    logic [3:0] irqEn_q;
    logic wbReq;
    logic wbWr;
    logic wrLane0;

    // ***************************************************
    // reset release
    // ***************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    // ***************************************************
    // cause inputs
    // ***************************************************
    rcf_sync #(.W(rcf_pkg::FLAG_W)) uSync (
        .clk(core_clk),
        .rstN(rstN),
        .asyncIn({sleepWake, idleWake, brownoutEvent, porEvent}),
        .syncOut(causeSync)
    );

    // edge detect so a long cause level sets once, then software may clear
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            causePrev_q <= 4'h0;
        end else begin
            causePrev_q <= causeSync;
        end
    end
    assign causeRise = causeSync & ~causePrev_q;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            fuseMeta_q <= 1'b0;
            fuse_q <= 1'b0;
        end else begin
            fuseMeta_q <= watchdogFuseEnable;
            fuse_q <= fuseMeta_q;
        end
    end

    // ***************************************************
    // bus decode
    // ***************************************************
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr = wbReq && wb_we_i;
    assign wrLane0 = wbWr && wb_sel_i[0];

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction

    // ***************************************************
    // cause flags
    // ***************************************************
    // flags live outside the block reset domain in a real part; here only
    // the power-on style nrst clears them, later resets leave them alone
    always_comb begin
        flags_d = flags_q;
        if (wrLane0 && hit(wb_adr_i, rcf_pkg::ADDR_STATUS)) begin
            flags_d = wb_dat_i[3:0];
        end
        flags_d[rcf_pkg::BIT_SLEEP] = flags_d[rcf_pkg::BIT_SLEEP]
            | causeRise[rcf_pkg::BIT_SLEEP];
        flags_d[rcf_pkg::BIT_IDLE] = flags_d[rcf_pkg::BIT_IDLE]
            | causeRise[rcf_pkg::BIT_IDLE];
        flags_d[rcf_pkg::BIT_BROWNOUT] = flags_d[rcf_pkg::BIT_BROWNOUT]
            | causeRise[rcf_pkg::BIT_BROWNOUT];
        flags_d[rcf_pkg::BIT_POR] = flags_d[rcf_pkg::BIT_POR]
            | causeRise[rcf_pkg::BIT_POR];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= rcf_pkg::FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ***************************************************
    // watchdog enable
    // ***************************************************
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            watchdogSoftEnable_q <= 1'b0;
        end else if (wrLane0 && hit(wb_adr_i, rcf_pkg::ADDR_WDT)) begin
            watchdogSoftEnable_q <= wb_dat_i[rcf_pkg::WDT_SOFT_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            watchdogRun <= 1'b0;
        end else begin
            watchdogRun <= fuse_q | watchdogSoftEnable_q;
        end
    end

    // ***************************************************
    // interrupt
    // ***************************************************
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            irqStat_q <= 4'h0;
        end else if (wrLane0 && hit(wb_adr_i, rcf_pkg::ADDR_IRQ_CLR)) begin
            // a new cause in the clear cycle survives
            irqStat_q <= (irqStat_q & ~wb_dat_i[3:0]) | causeRise;
        end else begin
            irqStat_q <= irqStat_q | causeRise;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            irqEn_q <= rcf_pkg::IRQ_EN_RST;
        end else if (wrLane0 && hit(wb_adr_i, rcf_pkg::ADDR_IRQ_EN)) begin
            irqEn_q <= wb_dat_i[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqEn_q);
        end
    end

    // ***************************************************
    // bus answer
    // ***************************************************
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i)
                    rcf_pkg::ADDR_STATUS: wb_dat_o <= {28'h0, flags_q};
                    rcf_pkg::ADDR_WDT: wb_dat_o <= {30'h0, watchdogRun, watchdogSoftEnable_q};
                    rcf_pkg::ADDR_IRQ_STAT: wb_dat_o <= {28'h0, irqStat_q};
                    rcf_pkg::ADDR_IRQ_EN: wb_dat_o <= {28'h0, irqEn_q};
                    default: wb_dat_o <= rcf_pkg::UNMAPPED_DATA;
                endcase
            end
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    property p_sleepSet;
        @(posedge core_clk) disable iff (!rstN)
        causeRise[rcf_pkg::BIT_SLEEP] |=> flags_q[rcf_pkg::BIT_SLEEP];
    endproperty
    a_sleepSet: assert property (p_sleepSet) else $error("sleep flag not set");

    property p_idleSet;
        @(posedge core_clk) disable iff (!rstN)
        causeRise[rcf_pkg::BIT_IDLE] |=> flags_q[rcf_pkg::BIT_IDLE];
    endproperty
    a_idleSet: assert property (p_idleSet) else $error("idle flag not set");

    property p_borSet;
        @(posedge core_clk) disable iff (!rstN)
        causeRise[rcf_pkg::BIT_BROWNOUT] |=> flags_q[rcf_pkg::BIT_BROWNOUT];
    endproperty
    a_borSet: assert property (p_borSet) else $error("brownout flag not set");

    property p_porSet;
        @(posedge core_clk) disable iff (!rstN)
        causeRise[rcf_pkg::BIT_POR] |=> flags_q[rcf_pkg::BIT_POR];
    endproperty
    a_porSet: assert property (p_porSet) else $error("power-on flag not set");

    property p_swWrite;
        @(posedge core_clk) disable iff (!rstN)
        (wrLane0 && wb_adr_i == rcf_pkg::ADDR_STATUS && causeRise == 4'h0)
            |=> flags_q == $past(wb_dat_i[3:0]);
    endproperty
    a_swWrite: assert property (p_swWrite) else $error("flag write lost");

    // a reset sequence would clear the registers that share the block reset
    property p_noReset;
        @(posedge core_clk) disable iff (!rstN)
        (wrLane0 && wb_adr_i == rcf_pkg::ADDR_STATUS && causeRise == 4'h0)
            |=> $stable(irqEn_q) && $stable(watchdogSoftEnable_q) && $stable(irqStat_q);
    endproperty
    a_noReset: assert property (p_noReset) else $error("write caused reset");

    property p_fuseForce;
        @(posedge core_clk) disable iff (!rstN)
        fuse_q |=> watchdogRun;
    endproperty
    a_fuseForce: assert property (p_fuseForce) else $error("fuse did not force watchdog");

    property p_hold;
        @(posedge core_clk) disable iff (!rstN)
        (!(wrLane0 && wb_adr_i == rcf_pkg::ADDR_STATUS) && causeRise == 4'h0)
            |=> $stable(flags_q);
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed without cause");

    property p_flagSetWins;
        @(posedge core_clk) disable iff (!rstN)
        (causeRise != 4'h0) |=> ((flags_q & $past(causeRise)) == $past(causeRise));
    endproperty
    a_flagSetWins: assert property (p_flagSetWins) else $error("cause lost to write");

    property p_irqSetWins;
        @(posedge core_clk) disable iff (!rstN)
        (causeRise != 4'h0) |=> ((irqStat_q & $past(causeRise)) == $past(causeRise));
    endproperty
    a_irqSetWins: assert property (p_irqSetWins) else $error("cause lost to irq clear");

    property p_softEnable;
        @(posedge core_clk) disable iff (!rstN)
        !fuse_q |=> (watchdogRun == $past(watchdogSoftEnable_q));
    endproperty
    a_softEnable: assert property (p_softEnable) else $error("soft enable not followed");

    property p_statusRead;
        @(posedge core_clk) disable iff (!rstN)
        (wbReq && !wb_we_i && wb_adr_i == rcf_pkg::ADDR_STATUS)
            |=> (wb_dat_o == {28'h0, $past(flags_q)});
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status read mismatch");

    property p_wdtRead;
        @(posedge core_clk) disable iff (!rstN)
        (wbReq && !wb_we_i && wb_adr_i == rcf_pkg::ADDR_WDT)
            |=> (wb_dat_o == {30'h0, $past(watchdogRun), $past(watchdogSoftEnable_q)});
    endproperty
    a_wdtRead: assert property (p_wdtRead) else $error("watchdog read mismatch");

    property p_ackAnswer;
        @(posedge core_clk) disable iff (!rstN)
        wbReq |=> wb_ack_o;
    endproperty
    a_ackAnswer: assert property (p_ackAnswer) else $error("request not acknowledged");

    property p_ackPulse;
        @(posedge core_clk) disable iff (!rstN)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");

    property p_irqLevel;
        @(posedge core_clk) disable iff (!rstN)
        1'b1 |=> (irq == |($past(irqStat_q) & $past(irqEn_q)));
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("irq level mismatch");
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// testbench for the reset-cause flag block: wishbone accesses, cause pulses, irq, watchdog
// assumes: design assertions sit in the rtl files; one 125 MHz clock, no partner model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk;
    logic nrst;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] cause;
    logic fuse;
    logic watchdogRun;
    logic irq;
    logic [31:0] rd;
    logic [31:0] expFlags;
    int nFail;
    int compares;

    reset_cause_flags u_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .porEvent(cause[rcf_pkg::BIT_POR]),
        .brownoutEvent(cause[rcf_pkg::BIT_BROWNOUT]),
        .idleWake(cause[rcf_pkg::BIT_IDLE]),
        .sleepWake(cause[rcf_pkg::BIT_SLEEP]),
        .watchdogFuseEnable(fuse),
        .watchdogRun(watchdogRun),
        .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t read word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t output bit %b, expected %b", $time, got, exp);
        end
    endtask

    // ack is sampled at the edge; request held until then, released right after
    // no wait limit here: a missing ack is caught by the watchdog process
    task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s = 4'hf);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= s;
        wbDatI <= d;
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
        wbXfer(1'b0, a, 32'h0000_0000);
        checkWord(rd, exp);
    endtask

    task automatic pulseCause(input int i);
        @(posedge core_clk);
        cause[i] <= 1'b1;
        repeat (6) @(posedge core_clk);
        cause[i] <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic endOfTest();
        $display("compares %0d mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        nFail = 0;
        compares = 0;
        nrst = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'hf;
        wbDatI = 32'h0000_0000;
        cause = 4'h0;
        fuse = 1'b0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        regRd(rcf_pkg::ADDR_STATUS, {28'h0, rcf_pkg::FLAGS_RST});
        regRd(rcf_pkg::ADDR_IRQ_EN, {28'h0, rcf_pkg::IRQ_EN_RST});
        regRd(8'h20, rcf_pkg::UNMAPPED_DATA);
        $display("test reset values done");
        expFlags = 32'h0000_0000;
        for (int i = 0; i < rcf_pkg::FLAG_W; i++) begin
            pulseCause(i);
            expFlags[i] = 1'b1;
            regRd(rcf_pkg::ADDR_STATUS, expFlags);
        end
        $display("test cause flags done");
        wbXfer(1'b1, rcf_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        wbXfer(1'b1, rcf_pkg::ADDR_IRQ_CLR, 32'h0000_000f);
        wbXfer(1'b1, rcf_pkg::ADDR_WDT, 32'h0000_0001);
        wbXfer(1'b1, rcf_pkg::ADDR_STATUS, 32'h0000_0005);
        regRd(rcf_pkg::ADDR_STATUS, 32'h0000_0005);
        wbXfer(1'b1, rcf_pkg::ADDR_STATUS, 32'h0000_000a);
        regRd(rcf_pkg::ADDR_STATUS, 32'h0000_000a);
        // a reset would have dropped the soft enable and the watchdog run bit
        regRd(rcf_pkg::ADDR_WDT, 32'h0000_0003);
        regRd(rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        $display("test software writes done");
        pulseCause(rcf_pkg::BIT_POR);
        regRd(rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        regRd(rcf_pkg::ADDR_STATUS, 32'h0000_000b);
        // lane 0 off: the status write must be ignored
        wbXfer(1'b1, rcf_pkg::ADDR_STATUS, 32'h0000_0000, 4'he);
        regRd(rcf_pkg::ADDR_STATUS, 32'h0000_000b);
        checkBit(irq, 1'b0);
        wbXfer(1'b1, rcf_pkg::ADDR_IRQ_EN, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        checkBit(irq, 1'b1);
        wbXfer(1'b1, rcf_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        checkBit(irq, 1'b0);
        regRd(rcf_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
        $display("test interrupt done");
        checkBit(watchdogRun, 1'b1);
        wbXfer(1'b1, rcf_pkg::ADDR_WDT, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        checkBit(watchdogRun, 1'b0);
        fuse <= 1'b1;
        repeat (4) @(posedge core_clk);
        checkBit(watchdogRun, 1'b1);
        regRd(rcf_pkg::ADDR_WDT, 32'h0000_0002);
        $display("test watchdog fuse done");
        endOfTest();
    end

    // whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        nFail++;
        $display("ERROR t=%0t watchdog expired", $time);
        endOfTest();
    end
endmodule
`default_nettype wire
